// *** include/msc_pkg.sv ***
// Constants for the spindle motor serial configuration block
package msc_pkg;
  // ============================================================
  // Serial word
  localparam int WORD_W = 24;
  localparam int B_RUN = 0;
  localparam int B_STEP = 1;
  localparam int B_BRAKE = 2;
  localparam int B_ILIM_LO = 3;
  localparam int B_ILIM_HI = 4;
  localparam int B_SPD_LO = 5;
  localparam int B_SPD_HI = 18;
  localparam int SPD_W = 14;
  localparam int SPD_SHIFT = 4;
  localparam int B_SRC = 19;
  localparam int B_POLE_LO = 20;
  localparam int B_POLE_HI = 21;
  localparam int B_MUX_HI = 22;
  localparam int B_MUX_LO = 23;
  localparam logic [23:0] WORD_RST = 24'h000000;
  // ============================================================
  // Codes
  localparam logic [1:0] POLE_8 = 2'h0;
  localparam logic [1:0] POLE_RSV = 2'h1;
  localparam logic [1:0] POLE_16 = 2'h2;
  localparam logic [1:0] POLE_12 = 2'h3;
  localparam logic [4:0] ZC_8 = 5'h08;
  localparam logic [4:0] ZC_16 = 5'h10;
  localparam logic [4:0] ZC_12 = 5'h0C;
  localparam logic [1:0] MUX_TICK = 2'h0;
  localparam logic [1:0] MUX_THERM = 2'h1;
  localparam logic [1:0] MUX_SYNC = 2'h2;
  localparam logic [1:0] MUX_ZC = 2'h3;
  // Current limit codes: bit3 is msb of code
  localparam logic [1:0] ILIM_1A2 = 2'h0;
  localparam logic [1:0] ILIM_1A = 2'h1;
  localparam logic [1:0] ILIM_600MA = 2'h2;
  localparam logic [1:0] ILIM_250MA = 2'h3;
  localparam int REF_W = 18;
  typedef enum logic [1:0] {
    ACQ_IDLE = 2'b00,
    ACQ_BOOST = 2'b01,
    ACQ_LOOP = 2'b10
  } msc_acq_t;
endpackage

// *** core/msc_serial_config.sv ***
// Serial configuration port, braking, revolution counter and speed-acquire control
`timescale 1ns/10ps
// What this block does
// - Boost asserts at motor start and holds until programmed speed first reached.
// - First overspeed error drops boost, releases filter clamp, returns filter control.
// - During boost, bypass filter, use maximum current, clamp filter node.
// - Chip select high: serial data and clock ignored, state kept.
// - Chip select low: data sampled into 24-bit shifter on rising clock.
// - Shifter copied into active latches only on chip select rising edge.
// - Bit zero low means sleep, high means run.
// - Bit one high: step only from startup oscillator, no back-EMF commutation.
// - Bit two high commands braking, low normal running.
// - Bits three and four choose one of four current limits.
// - Bits five to eighteen: active-low speed count, weights 16 to 131072.
// - Bit nineteen picks internal revolution signal or external sector input.
// - Bits twenty, twenty-one set pole count 8, 16 or 12.
// - Bits twenty-two, twenty-three steer the status output mux.
// - Reset low clears all configuration bits, forcing sleep.
// - Braking: all high sides off, all low sides on.
// - Brake pin or serial brake bit each start braking.
// - Once braking, low sides stay on until reset.
// - Zero-cross toggle flips each crossing and feeds revolution counter.
// - Revolution tick toggles per revolution; edges start reference, mark error.
module msc_serial_config
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic brake_pin,
  input wire logic zero_cross_evt,
  input wire logic sector_in,
  input wire logic motor_start,
  input wire logic err_fast,
  input wire logic therm_flag,
  input wire logic sync_flag,
  output logic run_enable_bit,
  output logic step_only_bit,
  output logic [1:0] ilim_code,
  output logic [17:0] speed_ref_count,
  output logic speed_source_select_bit,
  output logic [1:0] pole_code,
  output logic status_out,
  output logic brake_active,
  output logic [2:0] hs_on,
  output logic [2:0] ls_on,
  output logic speed_acquire_boost,
  output logic filter_clamp,
  output logic ilim_max_sel,
  output logic zero_cross_toggle,
  output logic revolution_tick
);
  // ============================================================
  // Synchronisers
  logic [2:0] cs_s_r, sclk_s_r, sd_s_r, brk_s_r, zc_s_r, sec_s_r;
  logic [2:0] cs_s_nxt, sclk_s_nxt, sd_s_nxt, brk_s_nxt, zc_s_nxt, sec_s_nxt;
  // Stage 0 is first flop, only stage 1 reads it; stage 2 used for edges
  always_comb
  begin
    cs_s_nxt = {cs_s_r[1:0], cs_n};
    sclk_s_nxt = {sclk_s_r[1:0], sclk};
    sd_s_nxt = {sd_s_r[1:0], sdata};
    brk_s_nxt = {brk_s_r[1:0], brake_pin};
    zc_s_nxt = {zc_s_r[1:0], zero_cross_evt};
    sec_s_nxt = {sec_s_r[1:0], sector_in};
  end
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cs_s_r <= 3'h7;
      sclk_s_r <= 3'h0;
      sd_s_r <= 3'h0;
      brk_s_r <= 3'h0;
      zc_s_r <= 3'h0;
      sec_s_r <= 3'h0;
    end
    else
    begin
      cs_s_r <= cs_s_nxt;
      sclk_s_r <= sclk_s_nxt;
      sd_s_r <= sd_s_nxt;
      brk_s_r <= brk_s_nxt;
      zc_s_r <= zc_s_nxt;
      sec_s_r <= sec_s_nxt;
    end
  end
  logic cs_low, sclk_rise, cs_rise;
  assign cs_low = !cs_s_r[1];
  assign sclk_rise = sclk_s_r[1] && !sclk_s_r[2];
  assign cs_rise = cs_s_r[1] && !cs_s_r[2];

  // ============================================================
  // Shifter and active latches
  logic [23:0] shift_r, shift_nxt, word_r, word_nxt;
  logic [1:0] pole_r, pole_nxt, pole_new;
  // Lower-numbered pole bit is the code's msb, as in the other two-bit fields
  assign pole_new = {shift_r[msc_pkg::B_POLE_LO], shift_r[msc_pkg::B_POLE_HI]};
  always_comb
  begin
    shift_nxt = shift_r;
    word_nxt = word_r;
    pole_nxt = pole_r;
    // Idle frame leaves everything untouched
    if (cs_low && sclk_rise)
      shift_nxt = {shift_r[22:0], sd_s_r[1]};
    if (cs_rise)
    begin
      word_nxt = shift_r;
      if (pole_new != msc_pkg::POLE_RSV)
        pole_nxt = pole_new;
    end
  end
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shift_r <= msc_pkg::WORD_RST;
      word_r <= msc_pkg::WORD_RST;
      pole_r <= msc_pkg::POLE_8;
    end
    else
    begin
      shift_r <= shift_nxt;
      word_r <= word_nxt;
      pole_r <= pole_nxt;
    end
  end

  // Field decode; order follows msb-first host framing
  assign run_enable_bit = word_r[msc_pkg::B_RUN];
  assign step_only_bit = word_r[msc_pkg::B_STEP];
  assign ilim_code = {word_r[msc_pkg::B_ILIM_LO], word_r[msc_pkg::B_ILIM_HI]};
  // Active low, weight of bit five is 16
  assign speed_ref_count = {~word_r[msc_pkg::B_SPD_HI:msc_pkg::B_SPD_LO], 4'h0};
  assign speed_source_select_bit = word_r[msc_pkg::B_SRC];
  assign pole_code = pole_r;

  // ============================================================
  // Braking
  logic brake_r, brake_nxt;
  always_comb
  begin
    brake_nxt = brake_r;
    if (brk_s_r[1] || word_r[msc_pkg::B_BRAKE])
      brake_nxt = 1'b1;
  end
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      brake_r <= 1'b0;
    else
      brake_r <= brake_nxt;
  end
  assign brake_active = brake_r;
  assign hs_on = brake_r ? 3'h0 : 3'h7;
  assign ls_on = brake_r ? 3'h7 : 3'h0;

  // ============================================================
  // Zero-cross toggle and revolution counter
  logic zc_tog_r, zc_tog_nxt, tick_r, tick_nxt;
  logic [4:0] zc_cnt_r, zc_cnt_nxt, zc_lim;
  logic zc_edge;
  assign zc_edge = zc_s_r[1] && !zc_s_r[2];
  always_comb
  begin
    case (pole_r)
      msc_pkg::POLE_16: zc_lim = msc_pkg::ZC_16;
      msc_pkg::POLE_12: zc_lim = msc_pkg::ZC_12;
      default: zc_lim = msc_pkg::ZC_8;
    endcase
  end
  always_comb
  begin
    zc_tog_nxt = zc_tog_r;
    zc_cnt_nxt = zc_cnt_r;
    tick_nxt = tick_r;
    if (zc_edge)
    begin
      zc_tog_nxt = !zc_tog_r;
      if (!speed_source_select_bit)
      begin
        if (zc_cnt_r + 5'h01 >= zc_lim)
        begin
          zc_cnt_nxt = 5'h00;
          tick_nxt = !tick_r;
        end
        else
          zc_cnt_nxt = zc_cnt_r + 5'h01;
      end
    end
    // Sector mode takes the external signal as the tick
    if (speed_source_select_bit)
      tick_nxt = sec_s_r[1];
  end
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      zc_tog_r <= 1'b0;
      zc_cnt_r <= 5'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      zc_tog_r <= zc_tog_nxt;
      zc_cnt_r <= zc_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign zero_cross_toggle = zc_tog_r;
  assign revolution_tick = tick_r;

  // ============================================================
  // Status mux
  logic stat_r, stat_nxt;
  always_comb
  begin
    case ({word_r[msc_pkg::B_MUX_HI], word_r[msc_pkg::B_MUX_LO]})
      msc_pkg::MUX_TICK: stat_nxt = tick_r;
      msc_pkg::MUX_THERM: stat_nxt = therm_flag;
      msc_pkg::MUX_SYNC: stat_nxt = sync_flag;
      msc_pkg::MUX_ZC: stat_nxt = zc_tog_r;
      default: stat_nxt = 1'b0;
    endcase
  end
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      stat_r <= 1'b0;
    else
      stat_r <= stat_nxt;
  end
  assign status_out = stat_r;

  // ============================================================
  // Speed acquire
  msc_pkg::msc_acq_t acq_r, acq_nxt;
  always_comb
  begin
    acq_nxt = acq_r;
    case (acq_r)
      msc_pkg::ACQ_IDLE: if (motor_start && run_enable_bit) acq_nxt = msc_pkg::ACQ_BOOST;
      msc_pkg::ACQ_BOOST: if (err_fast) acq_nxt = msc_pkg::ACQ_LOOP;
      msc_pkg::ACQ_LOOP: acq_nxt = msc_pkg::ACQ_LOOP;
      default: acq_nxt = msc_pkg::ACQ_IDLE;
    endcase
    // Sleep re-arms acquire for the next spin-up
    if (!run_enable_bit)
      acq_nxt = msc_pkg::ACQ_IDLE;
  end
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      acq_r <= msc_pkg::ACQ_IDLE;
    else
      acq_r <= acq_nxt;
  end
  assign speed_acquire_boost = (acq_r == msc_pkg::ACQ_BOOST);
  assign filter_clamp = speed_acquire_boost;
  assign ilim_max_sel = speed_acquire_boost;

  // ============================================================
  // Checks
  a_latch_on_cs: assert property (@(posedge mclk) disable iff (!arst_n)
    cs_rise |=> word_r == $past(shift_r))
    else $error("word not latched on chip select rise");
  a_word_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    !cs_rise |=> $stable(word_r))
    else $error("word changed outside chip select rise");
  a_shift_idle: assert property (@(posedge mclk) disable iff (!arst_n)
    !cs_low |=> $stable(shift_r))
    else $error("shifter moved with chip select high");
  a_shift_in: assert property (@(posedge mclk) disable iff (!arst_n)
    (cs_low && sclk_rise) |=> shift_r[0] == $past(sd_s_r[1]))
    else $error("data bit not shifted in");
  a_brake_sticky: assert property (@(posedge mclk) disable iff (!arst_n)
    brake_r |=> brake_r && ls_on == 3'h7 && hs_on == 3'h0)
    else $error("brake released before reset");
  a_brake_src: assert property (@(posedge mclk) disable iff (!arst_n)
    (brk_s_r[1] || word_r[msc_pkg::B_BRAKE]) |=> brake_r)
    else $error("brake source ignored");
  a_boost_end: assert property (@(posedge mclk) disable iff (!arst_n)
    (speed_acquire_boost && err_fast) |=> !speed_acquire_boost)
    else $error("boost kept after overspeed");
  a_pole_valid: assert property (@(posedge mclk) disable iff (!arst_n)
    pole_r != msc_pkg::POLE_RSV)
    else $error("reserved pole code active");
endmodule // msc_serial_config

// *** tb/msc_host_model.sv ***
// Host side model that writes frames into the serial configuration port
`timescale 1ns/10ps
module msc_host_model
(
  input wire logic mclk,
  output logic cs_n,
  output logic sclk,
  output logic sdata
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdata = 1'b0;
  end
  // ============================================================
  // Frame writer
  // Four mclk per level gives the 64 ns serial clock period
  task automatic send(input logic [31:0] w, input int n, input logic sel);
    int i;
    @(posedge mclk);
    cs_n <= ~sel;
    for (i = n - 1; i >= 0; i--)
    begin
      repeat (4) @(posedge mclk);
      sdata <= w[i];
      sclk <= 1'b0;
      repeat (4) @(posedge mclk);
      sclk <= 1'b1;
    end
    repeat (4) @(posedge mclk);
    sclk <= 1'b0;
    // Released data line must not keep the last bit
    sdata <= ~sdata;
    repeat (4) @(posedge mclk);
    cs_n <= 1'b1;
  endtask
endmodule // msc_host_model

// *** tb/tb_motor_ctrl_serial_config.sv ***
// Self-checking testbench for the serial configuration block
`timescale 1ns/10ps
module tb_motor_ctrl_serial_config;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic cs_n, sclk, sdata;
  logic brake_pin = 1'b0, zero_cross_evt = 1'b0, motor_start = 1'b0, err_fast = 1'b0;
  logic therm_flag = 1'b0, sync_flag = 1'b0, zc_exp = 1'b0, tick_exp = 1'b0, sector_in = 1'b0;
  logic run_enable_bit, step_only_bit, speed_source_select_bit, status_out, brake_active;
  logic speed_acquire_boost, filter_clamp, ilim_max_sel, zero_cross_toggle, revolution_tick;
  logic [1:0] ilim_code, pole_code, pole_exp = 2'h0;
  logic [17:0] speed_ref_count;
  logic [2:0] hs_on, ls_on;
  logic [31:0] w;
  int n_errors = 0, num_checks = 0, k;
  integer seed = 32'hf35542e6;
  always #4 mclk = ~mclk;
  msc_host_model u_host (.mclk, .cs_n, .sclk, .sdata);
  msc_serial_config u_dut (.mclk, .arst_n, .cs_n, .sclk, .sdata, .brake_pin, .zero_cross_evt,
    .sector_in, .motor_start, .err_fast, .therm_flag, .sync_flag, .run_enable_bit,
    .step_only_bit, .ilim_code, .speed_ref_count, .speed_source_select_bit, .pole_code,
    .status_out, .brake_active, .hs_on, .ls_on, .speed_acquire_boost, .filter_clamp,
    .ilim_max_sel, .zero_cross_toggle, .revolution_tick);
  // ============================================================
  // Helpers
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp, input string msg);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic exp_status(input logic [31:0] v);
    case ({v[22], v[23]})
      2'h1: return therm_flag;
      2'h2: return sync_flag;
      2'h3: return zc_exp;
      default: return tick_exp;
    endcase
  endfunction
  // Each bit left low adds its weight, 16 for bit five doubling upward
  function automatic logic [17:0] exp_speed(input logic [31:0] v);
    logic [17:0] s;
    s = 18'h0;
    for (int i = 5; i <= 18; i++)
      if (!v[i])
        s = s + (18'h1 << (i - 1));
    return s;
  endfunction
  // Outputs settle three mclk after chip select rises, status one more
  task automatic wr(input logic [31:0] v, input int n);
    u_host.send(v, n, 1'b1);
    repeat (6) @(posedge mclk);
  endtask
  task automatic check_cfg(input logic [31:0] v);
    if ({v[20], v[21]} != msc_pkg::POLE_RSV)
      pole_exp = {v[20], v[21]};
    // Sector mode makes the tick follow the sector input
    if (v[19])
      tick_exp = sector_in;
    chk(run_enable_bit, v[0], "run");
    chk(step_only_bit, v[1], "step");
    chk(ilim_code, {v[3], v[4]}, "ilim");
    chk(speed_ref_count, exp_speed(v), "speed");
    chk(speed_source_select_bit, v[19], "source");
    chk(pole_code, pole_exp, "pole");
    chk(status_out, exp_status(v), "status");
  endtask
  // ============================================================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({hs_on, ls_on, run_enable_bit}, 7'h70, "reset");
    $display("reset test done");
    w = 32'h00C00001;
    wr(w, 24);
    for (k = 0; k < 8; k++)
    begin
      zero_cross_evt <= 1'b1;
      repeat (4) @(posedge mclk);
      zero_cross_evt <= 1'b0;
      repeat (4) @(posedge mclk);
      zc_exp = ~zc_exp;
      chk(zero_cross_toggle, zc_exp, "toggle");
    end
    tick_exp = 1'b1;
    chk(revolution_tick, tick_exp, "tick");
    chk(status_out, zc_exp, "mux toggle");
    $display("revolution test done");
    motor_start <= 1'b1;
    @(posedge mclk);
    motor_start <= 1'b0;
    repeat (20) @(posedge mclk);
    chk({speed_acquire_boost, filter_clamp, ilim_max_sel}, 3'h7, "boost");
    err_fast <= 1'b1;
    @(posedge mclk);
    err_fast <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({speed_acquire_boost, filter_clamp, ilim_max_sel}, 3'h0, "loop");
    $display("boost test done");
    for (k = 0; k < 6; k++)
    begin
      w = $random(seed);
      w[2] = 1'b0;
      w[4:3] = k[1:0];
      w[21:20] = k[1:0] + 2'h1;
      w[23:22] = k[1:0];
      therm_flag <= 1'($random(seed));
      sync_flag <= 1'($random(seed));
      // Change the sector level only when the new word selects it
      if (w[19])
        sector_in <= 1'($random(seed));
      wr(w, 24 + (k % 2) * 4);
      check_cfg(w);
      u_host.send(~w, 24, 1'b0);
      repeat (6) @(posedge mclk);
      check_cfg(w);
    end
    $display("random write test done");
    brake_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    brake_pin <= 1'b0;
    repeat (6) @(posedge mclk);
    chk({hs_on, ls_on}, 6'h07, "brake pin");
    arst_n <= 1'b0;
    @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({hs_on, ls_on, run_enable_bit}, 7'h70, "second reset");
    wr(32'h00000004, 24);
    chk({hs_on, ls_on, brake_active}, 7'h0F, "brake bit");
    wr(32'h00000000, 24);
    chk({hs_on, ls_on}, 6'h07, "brake held");
    $display("brake test done");
    wrap_up();
  end
  // Cut a hang short well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule // tb_motor_ctrl_serial_config
